/* File: dv/debug_host_model.sv */
// Purpose: behavioural debug host on the serial clock and data pins
// Assumes: 160 ns serial period, clock idles low between words
// Notes:   data released after each word, the pull-down then holds it low
`timescale 1ns/1ps
module debug_host_model
(
   input  wire logic dout,
   output logic      clk_val,
   output logic      data_val,
   output logic      data_en
);
   logic [7:0] seen;
   initial
   begin
      clk_val  = 1'b0;
      data_val = 1'b0;
      data_en  = 1'b0;
      seen     = 8'h00;
   end
   task automatic send(input logic [7:0] w);
      for (int i = 7; i >= 0; i--)
      begin
         clk_val = 1'b1;
         #20;
         data_en  = 1'b1;
         data_val = w[i];
         #60;
         seen[i] = dout; // late in high phase, after the rise moved it
         clk_val = 1'b0;
         #80;
      end
      data_en = 1'b0;
   endtask
endmodule

/* File: dv/debug_serial_input_status_pins_tb.sv */
// Purpose: self-checking bench for the debug serial pin front end
// Assumes: default word width of 8
// Notes:   pin levels resolved here from the status enables; the data pin also from the host's enable
`timescale 1ns/1ps
module debug_serial_input_status_pins_tb;
   import debug_pins_pkg::*;
   logic        clk_sys = 1'b0;
   logic        resetn = 1'b0;
   logic        debug_mode = 1'b0;
   logic        status_cfg_out = 1'b0;
   logic [1:0]  cpu_status = 2'h0;
   logic [7:0]  tx_word = 8'h00;
   link_in_t    link_in;
   pin_drive_t  pin_drive;
   logic        tx_taken;
   logic        debug_data_out;
   logic        rx_valid;
   logic        hc;
   logic        hd;
   logic        hen;
   logic [7:0]  rx_word;
   logic [7:0]  rx_last = 8'h00;
   int          rx_count = 0;
   int          tx_count = 0;
   int          fails = 0;
   int          samples_checked = 0;
   logic [31:0] seed = 32'hE614;
   logic [7:0]  w;
   always #5 clk_sys = ~clk_sys;
   assign link_in.data = pin_drive.status_out_0_oe ? pin_drive.status_out_0 : (hen ? hd : 1'b0);
   assign link_in.clk  = pin_drive.status_out_1_oe ? pin_drive.status_out_1 : hc;
   always @(posedge clk_sys)
   begin
      if (rx_valid === 1'b1)
      begin
         rx_last  <= rx_word;
         rx_count <= rx_count + 1;
      end
      if (tx_taken === 1'b1)
         tx_count <= tx_count + 1;
   end
   debug_port_pins dut_u (.clk_sys(clk_sys), .resetn(resetn), .debug_mode(debug_mode),
      .status_cfg_out(status_cfg_out), .cpu_status(cpu_status), .link_in(link_in), .pin_drive(pin_drive),
      .tx_word(tx_word), .tx_taken(tx_taken), .debug_data_out(debug_data_out), .rx_word(rx_word),
      .rx_valid(rx_valid));
   debug_host_model host_u (.dout(debug_data_out), .clk_val(hc), .data_val(hd), .data_en(hen));
   function automatic logic [31:0] xs(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction
   function automatic logic [7:0] exp_pins(input logic [1:0] s, input logic c);
      return c ? {4'h0, s[0], 1'b1, s[1], 1'b1} : 8'h00;
   endfunction
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      samples_checked++;
      if (g !== e)
      begin
         fails++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task automatic xfer(input logic [7:0] d, input logic [7:0] t, input logic on);
      int n;
      int m;
      n = rx_count;
      m = tx_count;
      tx_word = t;
      #3;
      host_u.send(d);
      tick(8);
      chk("rx_count", 8'(on ? n + 1 : n), 8'(rx_count));
      chk("tx_taken", 8'(on ? m + 1 : m), 8'(tx_count));
      chk("tx_bits", on ? t : 8'h00, host_u.seen);
      if (on)
      begin
         chk("rx_word", d, rx_last);
      end
      $display("word test %h done", d);
   endtask
   initial
   begin
      #50000;
      fails++;
      conclude();
   end
   initial
   begin
      tick(16);
      chk("reset_pins", 8'h05, 8'(pin_drive));
      resetn = 1'b1;
      for (int i = 0; i < 24; i++)
      begin
         seed = xs(seed);
         cpu_status = seed[1:0];
         status_cfg_out = seed[2];
         tick(1);
         chk("status_pins", exp_pins(seed[1:0], seed[2]), 8'(pin_drive));
      end
      $display("status test done");
      status_cfg_out = 1'b1;
      debug_mode = 1'b1;
      tick(1);
      chk("turn_release", 8'h00, 8'(pin_drive));
      tick(4);
      for (int i = 0; i < 8; i++)
      begin
         seed = xs(seed);
         w = (i == 0) ? 8'h80 : (i == 1) ? 8'h01 : seed[7:0];
         xfer(w, seed[15:8], 1'b1);
      end
      debug_mode = 1'b0;
      status_cfg_out = 1'b0;
      tick(3);
      xfer(8'hA5, 8'hFF, 1'b0);
      status_cfg_out = 1'b1;
      cpu_status = 2'b10;
      tick(1);
      chk("status_back", exp_pins(2'b10, 1'b1), 8'(pin_drive));
      conclude();
   end
endmodule

/* File: include/debug_pins_pkg.sv */
// Purpose: shared constants and carriers for the debug serial pin front end
// Assumes: one system clock; pins sampled through two flip-flops
// Notes:   pin reset drive follows the shared pin: output, driven low
package debug_pins_pkg;

   localparam int   WORD_W_DEF      = 8;
   localparam logic DRIVE_RESET_OE  = 1'b1;
   localparam logic PIN_RESET_LEVEL = 1'b0;
   localparam logic IDLE_LEVEL      = 1'b0;

   typedef enum logic [1:0]
   {
      ST_STATUS = 2'b00,
      ST_TURN   = 2'b01,
      ST_DEBUG  = 2'b10
   } port_state_t;

   typedef struct packed
   {
      logic data;
      logic clk;
   } link_in_t;

   typedef struct packed
   {
      logic status_out_0;
      logic status_out_0_oe;
      logic status_out_1;
      logic status_out_1_oe;
   } pin_drive_t;

endpackage

/* File: verilog/debug_port_pins.sv */
// Purpose: pin front end of the debug serial port with shared status pins
// Assumes: debug_mode, status_cfg_out and cpu_status come from clk_sys logic
// Notes:   serial clock is oversampled; it must stay well below clk_sys / 4
`timescale 1ns/1ps
module debug_port_pins
   import debug_pins_pkg::*;
#(
   parameter int WORD_W = WORD_W_DEF
)
(
   input  wire logic              clk_sys,
   input  wire logic              resetn,
   input  wire logic              debug_mode,
   input  wire logic              status_cfg_out,
   input  wire logic [1:0]        cpu_status,
   input  wire link_in_t          link_in,
   output pin_drive_t             pin_drive,
   input  wire logic [WORD_W-1:0] tx_word,
   output logic                   tx_taken,
   output logic                   debug_data_out,
   output logic      [WORD_W-1:0] rx_word,
   output logic                   rx_valid
);

   localparam int CW = (WORD_W > 1) ? $clog2(WORD_W) : 1;
   localparam logic [CW-1:0] LAST_BIT = CW'(WORD_W - 1);
   localparam logic [CW-1:0] FIRST_BIT = '0;

   function automatic logic is_last(input logic [CW-1:0] c);
      return c == LAST_BIT;
   endfunction

   link_in_t          link_sync;
   logic              clk_prev;
   logic              clk_fall;
   logic              clk_rise;
   port_state_t       state;
   port_state_t       next_state;
   logic [WORD_W-1:0] shreg;
   logic [WORD_W-1:0] next_shreg;
   logic [WORD_W-1:0] tx_shift;
   logic [CW-1:0]     bit_cnt;
   logic              in_debug;
   logic              settle_early;
   logic              link_settled;

   pin_sync #(
      .W (2)
   ) u_sync (
      .clk_sys  (clk_sys),
      .resetn   (resetn),
      .async_in (link_in),
      .sync_out (link_sync)
   );

   // edges of the serial clock, seen on the synchronised copy
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
         clk_prev <= IDLE_LEVEL;
      else
         clk_prev <= link_sync.clk;
   end

   // the last status level can still sit in the synchroniser and the edge register
   // after release, and it would read as a serial clock edge, so edges wait a flush
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         settle_early <= 1'b0;
         link_settled <= 1'b0;
      end
      else
      begin
         settle_early <= in_debug;
         link_settled <= settle_early & in_debug;
      end
   end

   assign clk_fall = link_settled & clk_prev & ~link_sync.clk;
   assign clk_rise = link_settled & ~clk_prev & link_sync.clk;
   assign in_debug = (state == ST_DEBUG);

   // one idle cycle between status drive and input keeps the pin free of contention
   always_comb
   begin
      next_state = state;
      case (state)
         ST_STATUS:
            if (debug_mode)
               next_state = ST_TURN;
         ST_TURN:
            if (debug_mode)
               next_state = ST_DEBUG;
            else
               next_state = ST_STATUS;
         ST_DEBUG:
            if (!debug_mode)
               next_state = ST_STATUS;
         default:
            next_state = ST_STATUS;
      endcase
   end

   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
         state <= ST_STATUS;
      else
         state <= next_state;
   end

   // status drive; enable drops the cycle after debug mode is raised
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         pin_drive.status_out_0    <= PIN_RESET_LEVEL;
         pin_drive.status_out_0_oe <= DRIVE_RESET_OE;
         pin_drive.status_out_1    <= PIN_RESET_LEVEL;
         pin_drive.status_out_1_oe <= DRIVE_RESET_OE;
      end
      else if (state == ST_STATUS && !debug_mode && status_cfg_out)
      begin
         pin_drive.status_out_0    <= cpu_status[0];
         pin_drive.status_out_0_oe <= 1'b1;
         pin_drive.status_out_1    <= cpu_status[1];
         pin_drive.status_out_1_oe <= 1'b1;
      end
      else
      begin
         pin_drive.status_out_0    <= PIN_RESET_LEVEL;
         pin_drive.status_out_0_oe <= 1'b0;
         pin_drive.status_out_1    <= PIN_RESET_LEVEL;
         pin_drive.status_out_1_oe <= 1'b0;
      end
   end

   assign next_shreg = {shreg[WORD_W-2:0], link_sync.data};

   // receive: sample on falling edge, only while in debug mode
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         shreg   <= '0;
         bit_cnt <= FIRST_BIT;
      end
      else if (!in_debug)
      begin
         shreg   <= '0;
         bit_cnt <= FIRST_BIT;
      end
      else if (clk_fall)
      begin
         shreg <= next_shreg;
         if (is_last(bit_cnt))
            bit_cnt <= FIRST_BIT;
         else
            bit_cnt <= bit_cnt + CW'(1);
      end
   end

   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         rx_word  <= '0;
         rx_valid <= 1'b0;
      end
      else if (in_debug && clk_fall && is_last(bit_cnt))
      begin
         rx_word  <= next_shreg;
         rx_valid <= 1'b1;
      end
      else
         rx_valid <= 1'b0;
   end

   // transmit: a word is taken at its first rising edge, then shifted out msb first
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         tx_shift       <= '0;
         debug_data_out <= IDLE_LEVEL;
         tx_taken       <= 1'b0;
      end
      else if (!in_debug)
      begin
         tx_shift       <= '0;
         debug_data_out <= IDLE_LEVEL;
         tx_taken       <= 1'b0;
      end
      else if (clk_rise && bit_cnt == FIRST_BIT)
      begin
         debug_data_out <= tx_word[WORD_W-1];
         tx_shift       <= {tx_word[WORD_W-2:0], 1'b0};
         tx_taken       <= 1'b1;
      end
      else if (clk_rise)
      begin
         debug_data_out <= tx_shift[WORD_W-1];
         tx_shift       <= {tx_shift[WORD_W-2:0], 1'b0};
         tx_taken       <= 1'b0;
      end
      else
         tx_taken <= 1'b0;
   end

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!resetn);

   sequence enter_debug_s;
      $rose(debug_mode) && state == ST_STATUS;
   endsequence

   sequence released_s;
      !pin_drive.status_out_0_oe && !pin_drive.status_out_1_oe;
   endsequence

   rx_gate_a:
   assert property (!in_debug |=> !rx_valid && bit_cnt == FIRST_BIT)
      else $error("serial input accepted outside debug mode");

   msb_order_a:
   assert property (in_debug && clk_fall && is_last(bit_cnt) |=>
                    rx_valid && rx_word == {$past(shreg[WORD_W-2:0]), $past(link_sync.data)})
      else $error("received word not assembled msb first");

   status_drive_a:
   assert property (state == ST_STATUS && !debug_mode && status_cfg_out |=>
                    pin_drive.status_out_0_oe && pin_drive.status_out_1_oe
                    && pin_drive.status_out_0 == $past(cpu_status[0])
                    && pin_drive.status_out_1 == $past(cpu_status[1]))
      else $error("status not driven outside debug mode");

   release_turn_a:
   assert property (enter_debug_s |=> released_s ##1 (released_s and (state == ST_DEBUG)))
      else $error("shared pin not released on turn to input");

   paced_shift_a:
   assert property (in_debug && bit_cnt != $past(bit_cnt) && $past(in_debug) |-> $past(clk_fall))
      else $error("shift without serial clock edge");

   fall_sample_a:
   assert property (in_debug && !clk_fall |=> shreg == $past(shreg))
      else $error("input sampled off the falling edge");

   rise_change_a:
   assert property (in_debug && $past(in_debug) && debug_data_out != $past(debug_data_out)
                    |-> $past(clk_rise))
      else $error("output changed off the rising edge");

endmodule

/* File: verilog/pin_sync.sv */
// Purpose: two-stage synchroniser for pin inputs
// Assumes: inputs asynchronous to clk_sys
// Notes:   first stage is read by the second stage only
`timescale 1ns/1ps
module pin_sync
   import debug_pins_pkg::*;
#(
   parameter int W = 2
)
(
   input  wire logic         clk_sys,
   input  wire logic         resetn,
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);

   logic [W-1:0] meta;

   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         meta     <= '0;
         sync_out <= '0;
      end
      else
      begin
         meta     <= async_in;
         sync_out <= meta;
      end
   end

endmodule
